// ==== rtl/tcr_pkg.sv ====
package tcr_pkg;

  // ****************************************
  // Bus shape
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int MODE_W = 3;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
  localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h08;
  localparam logic [7:0] OFS_MASK     = 8'h0C;
  localparam logic [7:0] OFS_COMMAND  = 8'h10;
  localparam logic [7:0] OFS_RELOAD   = 8'h14;
  localparam logic [7:0] OFS_PRESCALE = 8'h18;
  localparam logic [7:0] OFS_COMPARE  = 8'h1C;
  localparam logic [7:0] OFS_CHAN     = 8'h20;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int C1_RUN      = 0;
  localparam int C1_UPD_BLK  = 1;
  localparam int C1_NARROW   = 2;
  localparam int C1_ONE_SHOT = 3;
  localparam int C1_RLD_BUF  = 7;
  localparam int C1_DIV_LO   = 8;
  localparam int C1_DIV_HI   = 9;
  localparam int C2_PRELOAD  = 0;
  localparam int C2_UPD_SEL  = 2;
  localparam int CMD_UPDATE  = 0;
  localparam int CMD_COMMUTE = 1;
  localparam int ST_UPDATE   = 0;
  localparam int ST_COMMUTE  = 1;
  localparam int ST_TRIGGER  = 2;
  localparam int ST_W        = 3;
  localparam int CH_OUT_EN   = 0;
  localparam int CH_COMP_EN  = 1;
  localparam int CH_MODE_LO  = 4;
  localparam int CH_MODE_HI  = 6;

  // ****************************************
  // Reset values and writable masks
  // ****************************************
  localparam logic [15:0] RST_CTRL_ONE = 16'h0000;
  localparam logic [15:0] RST_CTRL_TWO = 16'h0000;
  localparam logic [15:0] RST_DATA     = 16'h0000;
  localparam logic [2:0]  RST_STATUS   = 3'h0;
  localparam logic [15:0] MSK_CTRL_ONE = 16'h038F;
  localparam logic [15:0] MSK_CTRL_TWO = 16'h0005;
  localparam logic [15:0] MSK_CHAN     = 16'h0073;

  // ****************************************
  // Sampling clock divider codes
  // ****************************************
  typedef enum logic [1:0] {
    TCR_DIV_ONE  = 2'b00,
    TCR_DIV_TWO  = 2'b01,
    TCR_DIV_FOUR = 2'b10,
    TCR_DIV_RSVD = 2'b11
  } tcr_div_e;

endpackage

// ==== rtl/tcr_edge_sync.sv ====
`timescale 1ns/1ps
module tcr_edge_sync
  import tcr_pkg::*;
(
  input  wire logic core_clk_in,
  input  wire logic reset_n_in,
  input  wire logic async_in,
  output logic      rise_out
);

  // ****************************************
  // Two-stage synchroniser and edge detect
  // ****************************************
  logic meta;
  logic stable;
  logic stable_d;

  // First stage is read only by the second stage
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta     <= 1'b0;
      stable   <= 1'b0;
      stable_d <= 1'b0;
    end else begin
      meta     <= async_in;
      stable   <= meta;
      stable_d <= stable;
    end
  end

  assign rise_out = stable & ~stable_d;

endmodule

// ==== rtl/tcr_sample_div.sv ====
`timescale 1ns/1ps
module tcr_sample_div
  import tcr_pkg::*;
(
  input  wire logic       core_clk_in,
  input  wire logic       reset_n_in,
  input  wire logic [1:0] div_code_in,
  output logic            tick_out
);

  // ****************************************
  // Sampling tick divider
  // ****************************************
  logic [1:0] phase;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // Reserved code falls back to the undivided rate
  always_comb begin
    unique case (tcr_div_e'(div_code_in))
      TCR_DIV_ONE:  tick_out = 1'b1; // R9
      TCR_DIV_TWO:  tick_out = (phase[0] == 1'b0); // R9
      TCR_DIV_FOUR: tick_out = (phase == 2'h0); // R9
      TCR_DIV_RSVD: tick_out = 1'b1;
    endcase
  end

  a_div_two_gap: assert property ( // R9
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (tick_out && div_code_in == 2'h1) ##1 (div_code_in == 2'h1)
      |-> !tick_out)
    else $error("divide-by-two tick came twice in a row");

  a_div_four_gap: assert property ( // R9
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (tick_out && div_code_in == 2'h2) ##1 (div_code_in == 2'h2)[*3]
      |-> !tick_out)
    else $error("divide-by-four tick came too early");

endmodule

// ==== rtl/tcr_timer_ctrl.sv ====
// Function
// R1: The counter counts only while counter_run is one and halts while zero.
// R2: Software sets counter_run itself for external clock, gated or encoder use.
// R3: In slave trigger mode a trigger edge sets counter_run by hardware.
// R4: Update events come from overflow, update_trigger_bit or slave unless blocked.
// R5: Each update event moves buffered reload, prescale and compare to active.
// R6: Narrow source lets only overflow raise the update interrupt or request.
// R7: In one-shot mode the next update event clears counter_run.
// R8: Reload writes act at once unless buffering defers them to an update.
// R9: The sample clock divider gives one, two or four clock periods.
// R10: With preload on, channel controls act only after commutation_trigger.
// R11: With update select set, a trigger_input rising edge also applies them.
// R12: Reserved bits of both control registers read zero and ignore writes.
`timescale 1ns/1ps
module tcr_timer_ctrl
  import tcr_pkg::*;
(
  input  wire logic              core_clk_in,
  input  wire logic              reset_n_in,
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [DATA_W-1:0] reg_wdata_in,
  input  wire logic              reg_write_in,
  input  wire logic              reg_read_in,
  output logic      [DATA_W-1:0] reg_rdata_out,
  input  wire logic              counter_overflow_in,
  input  wire logic              slave_update_in,
  input  wire logic              slave_trigger_mode_in,
  input  wire logic              trigger_input_in,
  output logic                   counter_run_out,
  output logic                   update_event_out,
  output logic                   update_request_out,
  output logic                   sample_tick_out,
  output logic      [DATA_W-1:0] reload_value_out,
  output logic      [DATA_W-1:0] prescale_value_out,
  output logic      [DATA_W-1:0] channel_compare_value_out,
  output logic                   channel_output_enable_out,
  output logic                   complement_output_enable_out,
  output logic      [MODE_W-1:0] output_compare_mode_out,
  output logic                   irq_out
);

  // ****************************************
  // Storage
  // ****************************************
  logic [DATA_W-1:0] ctrl_one;
  logic [DATA_W-1:0] ctrl_two;
  logic              counter_run;
  logic [ST_W-1:0]   status;
  logic [ST_W-1:0]   mask;
  logic [DATA_W-1:0] reload_buf;
  logic [DATA_W-1:0] prescale_buf;
  logic [DATA_W-1:0] compare_buf;
  logic [DATA_W-1:0] chan_shadow;

  // ****************************************
  // Decode
  // ****************************************
  logic wr_ctrl_one;
  logic wr_ctrl_two;
  logic wr_status;
  logic wr_mask;
  logic wr_command;
  logic wr_reload;
  logic wr_prescale;
  logic wr_compare;
  logic wr_chan;

  assign wr_ctrl_one = reg_write_in && reg_addr_in == OFS_CTRL_ONE;
  assign wr_ctrl_two = reg_write_in && reg_addr_in == OFS_CTRL_TWO;
  assign wr_status   = reg_write_in && reg_addr_in == OFS_STATUS;
  assign wr_mask     = reg_write_in && reg_addr_in == OFS_MASK;
  assign wr_command  = reg_write_in && reg_addr_in == OFS_COMMAND;
  assign wr_reload   = reg_write_in && reg_addr_in == OFS_RELOAD;
  assign wr_prescale = reg_write_in && reg_addr_in == OFS_PRESCALE;
  assign wr_compare  = reg_write_in && reg_addr_in == OFS_COMPARE;
  assign wr_chan     = reg_write_in && reg_addr_in == OFS_CHAN;

  // ****************************************
  // Control fields
  // ****************************************
  logic update_block;
  logic update_source_narrow;
  logic one_shot_enable;
  logic reload_buffer_enable;
  logic channel_ctrl_preload;
  logic channel_ctrl_update_select;
  logic update_trigger_bit;
  logic commutation_trigger;

  assign update_block               = ctrl_one[C1_UPD_BLK];
  assign update_source_narrow       = ctrl_one[C1_NARROW];
  assign one_shot_enable            = ctrl_one[C1_ONE_SHOT];
  assign reload_buffer_enable       = ctrl_one[C1_RLD_BUF];
  assign channel_ctrl_preload       = ctrl_two[C2_PRELOAD];
  assign channel_ctrl_update_select = ctrl_two[C2_UPD_SEL];
  // Command bits are strobes; they store nothing and read as zero
  assign update_trigger_bit  = wr_command && reg_wdata_in[CMD_UPDATE];
  assign commutation_trigger = wr_command && reg_wdata_in[CMD_COMMUTE];

  // ****************************************
  // Trigger input and sampling tick
  // ****************************************
  logic trig_rise;

  tcr_edge_sync u_trig_sync (
    .core_clk_in (core_clk_in),
    .reset_n_in  (reset_n_in),
    .async_in    (trigger_input_in),
    .rise_out    (trig_rise)
  );

  tcr_sample_div u_sample_div (
    .core_clk_in (core_clk_in),
    .reset_n_in  (reset_n_in),
    .div_code_in (ctrl_one[C1_DIV_HI:C1_DIV_LO]),
    .tick_out    (sample_tick_out)
  );

  // ****************************************
  // Update event and request
  // ****************************************
  logic any_update_src;
  logic trig_start;
  logic chan_commit;

  assign any_update_src = counter_overflow_in | update_trigger_bit
                        | slave_update_in;
  assign update_event_out = !update_block && any_update_src; // R4
  assign update_request_out = update_event_out
    && (!update_source_narrow || counter_overflow_in); // R6
  assign trig_start = slave_trigger_mode_in && trig_rise; // R3
  // Without preload the controls already act on write
  assign chan_commit = channel_ctrl_preload && (commutation_trigger
    || (channel_ctrl_update_select && trig_rise)); // R10 R11

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_one <= RST_CTRL_ONE;
      ctrl_two <= RST_CTRL_TWO;
    end else begin
      if (wr_ctrl_one) begin
        ctrl_one <= reg_wdata_in & MSK_CTRL_ONE & ~16'h0001; // R12
      end
      if (wr_ctrl_two) begin
        ctrl_two <= reg_wdata_in & MSK_CTRL_TWO; // R12
      end
    end
  end

  // One-shot stop beats a same-cycle software start or trigger,
  // so a pulse train can never restart itself on its own edge
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      counter_run <= 1'b0;
    end else if (update_event_out && one_shot_enable) begin
      counter_run <= 1'b0; // R7
    end else if (wr_ctrl_one) begin
      counter_run <= reg_wdata_in[C1_RUN]; // R1 R2
    end else if (trig_start) begin
      counter_run <= 1'b1; // R3
    end
  end

  assign counter_run_out = counter_run; // R1

  // ****************************************
  // Buffered values
  // ****************************************
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reload_buf   <= RST_DATA;
      prescale_buf <= RST_DATA;
      compare_buf  <= RST_DATA;
    end else begin
      if (wr_reload) begin
        reload_buf <= reg_wdata_in;
      end
      if (wr_prescale) begin
        prescale_buf <= reg_wdata_in;
      end
      if (wr_compare) begin
        compare_buf <= reg_wdata_in;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reload_value_out <= RST_DATA;
    end else if (wr_reload && !reload_buffer_enable) begin
      reload_value_out <= reg_wdata_in; // R8
    end else if (update_event_out) begin
      reload_value_out <= reload_buf; // R5 R8
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prescale_value_out        <= RST_DATA;
      channel_compare_value_out <= RST_DATA;
    end else if (update_event_out) begin
      prescale_value_out        <= prescale_buf; // R5
      channel_compare_value_out <= compare_buf; // R5
    end
  end

  // ****************************************
  // Channel controls
  // ****************************************
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      chan_shadow <= RST_DATA;
    end else if (wr_chan) begin
      chan_shadow <= reg_wdata_in & MSK_CHAN;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      channel_output_enable_out    <= 1'b0;
      complement_output_enable_out <= 1'b0;
      output_compare_mode_out      <= 3'h0;
    end else if (wr_chan && !channel_ctrl_preload) begin
      channel_output_enable_out    <= reg_wdata_in[CH_OUT_EN]; // R10
      complement_output_enable_out <= reg_wdata_in[CH_COMP_EN]; // R10
      output_compare_mode_out <= reg_wdata_in[CH_MODE_HI:CH_MODE_LO]; // R10
    end else if (chan_commit) begin
      channel_output_enable_out    <= chan_shadow[CH_OUT_EN]; // R11
      complement_output_enable_out <= chan_shadow[CH_COMP_EN]; // R11
      output_compare_mode_out <= chan_shadow[CH_MODE_HI:CH_MODE_LO]; // R11
    end
  end

  // ****************************************
  // Interrupt status and mask
  // ****************************************
  logic [ST_W-1:0] status_set;

  assign status_set = {trig_start, chan_commit, update_request_out};

  // Set wins over a same-cycle write-one-to-clear
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      status <= RST_STATUS;
    end else if (wr_status) begin
      status <= (status & ~reg_wdata_in[ST_W-1:0]) | status_set;
    end else begin
      status <= status | status_set;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mask <= RST_STATUS;
    end else if (wr_mask) begin
      mask <= reg_wdata_in[ST_W-1:0];
    end
  end

  assign irq_out = |(status & mask);

  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= RST_DATA;
    end else if (reg_read_in) begin
      unique case (reg_addr_in)
        OFS_CTRL_ONE: reg_rdata_out <= ctrl_one
                                     | {15'h0000, counter_run}; // R12
        OFS_CTRL_TWO: reg_rdata_out <= ctrl_two; // R12
        OFS_STATUS:   reg_rdata_out <= {13'h0000, status};
        OFS_MASK:     reg_rdata_out <= {13'h0000, mask};
        OFS_RELOAD:   reg_rdata_out <= reload_buf;
        OFS_PRESCALE: reg_rdata_out <= prescale_buf;
        OFS_COMPARE:  reg_rdata_out <= compare_buf;
        OFS_CHAN:     reg_rdata_out <= chan_shadow;
        default:      reg_rdata_out <= RST_DATA;
      endcase
    end else begin
      reg_rdata_out <= RST_DATA;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_run_from_write: assert property ( // R1
    @(posedge core_clk_in) disable iff (!reset_n_in)
    wr_ctrl_one && !(update_event_out && one_shot_enable)
      |=> counter_run_out == $past(reg_wdata_in[C1_RUN]))
    else $error("counter_run did not follow the write");

  a_trig_start_run: assert property ( // R3
    @(posedge core_clk_in) disable iff (!reset_n_in)
    slave_trigger_mode_in && trig_rise && !wr_ctrl_one
      && !(update_event_out && one_shot_enable)
      |=> counter_run_out)
    else $error("trigger did not start the counter");

  a_update_blocked: assert property ( // R4
    @(posedge core_clk_in) disable iff (!reset_n_in)
    update_block |-> !update_event_out && !update_request_out)
    else $error("update event while blocked");

  a_update_cause: assert property ( // R4
    @(posedge core_clk_in) disable iff (!reset_n_in)
    !update_block && (counter_overflow_in || slave_update_in)
      |-> update_event_out)
    else $error("update source gave no update event");

  a_update_transfer: assert property ( // R5
    @(posedge core_clk_in) disable iff (!reset_n_in)
    update_event_out |=> prescale_value_out == $past(prescale_buf)
      && channel_compare_value_out == $past(compare_buf))
    else $error("buffered values not transferred");

  a_narrow_source: assert property ( // R6
    @(posedge core_clk_in) disable iff (!reset_n_in)
    update_source_narrow && !counter_overflow_in
      |-> !update_request_out)
    else $error("narrow source raised a request");

  a_wide_source: assert property ( // R6
    @(posedge core_clk_in) disable iff (!reset_n_in)
    !update_source_narrow && update_event_out |-> update_request_out)
    else $error("update event without request");

  a_one_shot_stop: assert property ( // R7
    @(posedge core_clk_in) disable iff (!reset_n_in)
    update_event_out && one_shot_enable |=> !counter_run_out)
    else $error("one-shot did not stop the counter");

  a_reload_direct: assert property ( // R8
    @(posedge core_clk_in) disable iff (!reset_n_in)
    wr_reload && !reload_buffer_enable
      |=> reload_value_out == $past(reg_wdata_in))
    else $error("unbuffered reload not immediate");

  a_reload_held: assert property ( // R8
    @(posedge core_clk_in) disable iff (!reset_n_in)
    reload_buffer_enable && !update_event_out
      |=> $stable(reload_value_out))
    else $error("buffered reload changed without update");

  a_preload_held: assert property ( // R10
    @(posedge core_clk_in) disable iff (!reset_n_in)
    channel_ctrl_preload && !commutation_trigger
      && !(channel_ctrl_update_select && trig_rise)
      |=> $stable(output_compare_mode_out)
        && $stable(channel_output_enable_out))
    else $error("preloaded channel control changed early");

  a_trig_commit: assert property ( // R11
    @(posedge core_clk_in) disable iff (!reset_n_in)
    channel_ctrl_preload && channel_ctrl_update_select && trig_rise
      |=> output_compare_mode_out
        == $past(chan_shadow[CH_MODE_HI:CH_MODE_LO]))
    else $error("trigger edge did not apply channel controls");

  a_reserved_zero: assert property ( // R12
    @(posedge core_clk_in) disable iff (!reset_n_in)
    reg_read_in && reg_addr_in == OFS_CTRL_TWO
      |=> (reg_rdata_out & ~MSK_CTRL_TWO) == 16'h0000)
    else $error("reserved bits read non-zero");

endmodule

// ==== testbench/tcr_timer_ctrl_tb_top.sv ====
`timescale 1ns/1ps
module tcr_timer_ctrl_tb_top
  import tcr_pkg::*;
;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  typedef struct packed {
    logic [7:0]  a;
    logic [15:0] w;
    logic [15:0] e;
  } tcr_row_s;

  logic        clk      = 1'b0;
  logic        rst_n    = 1'b0;
  logic [7:0]  addr     = 8'h00;
  logic [15:0] wdata    = 16'h0000;
  logic        wr_en    = 1'b0;
  logic        rd_en    = 1'b0;
  logic        ovf      = 1'b0;
  logic        slv_upd  = 1'b0;
  logic        trg_mode = 1'b0;
  logic        trg      = 1'b0;
  logic [15:0] rdata;
  logic [15:0] rld;
  logic [15:0] prescale_value;
  logic [15:0] cmp;
  logic        run;
  logic        update_event;
  logic        ureq;
  logic        tick;
  logic        oen;
  logic        cen;
  logic        irq;
  logic [2:0]  ocm;
  logic [15:0] chan;
  int          num_errors = 0;
  int          checked    = 0;
  int          cycles     = 0;
  // Write data beside the readback it should give
  tcr_row_s    rows [11] = '{
    '{8'h00, 16'hFFFF, 16'h038F}, '{8'h00, 16'h0000, 16'h0000},
    '{8'h04, 16'hFFFF, 16'h0005}, '{8'h04, 16'h0000, 16'h0000},
    '{8'h30, 16'hFFFF, 16'h0000}, '{8'h10, 16'h0000, 16'h0000},
    '{8'h14, 16'h1234, 16'h1234}, '{8'h0C, 16'hFFFF, 16'h0007},
    '{8'h0C, 16'h0000, 16'h0000}, '{8'h20, 16'hFFFF, 16'h0073},
    '{8'h20, 16'h0000, 16'h0000}};

  assign chan = {9'h000, ocm, 2'h0, cen, oen};

  always #2 clk = ~clk;

  // Far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      summarize();
    end
  end

  tcr_timer_ctrl u_dut (
    .core_clk_in                  (clk),
    .reset_n_in                   (rst_n),
    .reg_addr_in                  (addr),
    .reg_wdata_in                 (wdata),
    .reg_write_in                 (wr_en),
    .reg_read_in                  (rd_en),
    .reg_rdata_out                (rdata),
    .counter_overflow_in          (ovf),
    .slave_update_in              (slv_upd),
    .slave_trigger_mode_in        (trg_mode),
    .trigger_input_in             (trg),
    .counter_run_out              (run),
    .update_event_out             (update_event),
    .update_request_out           (ureq),
    .sample_tick_out              (tick),
    .reload_value_out             (rld),
    .prescale_value_out           (prescale_value),
    .channel_compare_value_out    (cmp),
    .channel_output_enable_out    (oen),
    .complement_output_enable_out (cen),
    .output_compare_mode_out      (ocm),
    .irq_out                      (irq)
  );

  // ****************************************
  // Bus cycles and checks
  // ****************************************
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  // Effects of a write are settled 1 ns after the taking edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask

  // One cycle of overflow, slave update or command update
  task automatic cause(input int s, output logic e, output logic q);
    @(posedge clk);
    ovf     <= (s == 0);
    slv_upd <= (s == 1);
    wr_en   <= (s == 2);
    addr    <= OFS_COMMAND;
    wdata   <= 16'h0001;
    #1;
    e = update_event;
    q = ureq;
    @(posedge clk);
    ovf     <= 1'b0;
    slv_upd <= 1'b0;
    wr_en   <= 1'b0;
    #1;
  endtask

  // Long pulse so the synchroniser sees the edge
  task automatic trig();
    @(posedge clk);
    trg <= 1'b1;
    repeat (8) @(posedge clk);
    trg <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic done(input string n);
    $display("test %s done", n);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    logic [15:0] v;
    logic        e;
    logic        q;
    int          n;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, v);
      chk("readback", rows[i].e, v);
    end
    done("access");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a <= 32; a += 4) begin
      rd(8'(a), v);
      chk("reset value", 16'h0000, v);
    end
    chk("run", 16'h0000, 16'(run));
    chk("channel", 16'h0000, chan);
    done("reset");
    wr(OFS_CTRL_ONE, 16'h0001);
    chk("run", 16'h0001, 16'(run));
    wr(OFS_CTRL_ONE, 16'h0000);
    chk("run", 16'h0000, 16'(run));
    trig();
    chk("run", 16'h0000, 16'(run));
    @(posedge clk);
    trg_mode <= 1'b1;
    trig();
    chk("run", 16'h0001, 16'(run));
    rd(OFS_STATUS, v);
    chk("status", 16'h0004, v);
    @(posedge clk);
    trg_mode <= 1'b0;
    wr(OFS_CTRL_ONE, 16'h0000);
    done("run");
    // Plain, narrow and blocked modes against every source
    for (int m = 0; m < 3; m++) begin
      wr(OFS_CTRL_ONE, 16'(m == 1 ? 4 : m == 2 ? 2 : 0));
      for (int s = 0; s < 3; s++) begin
        cause(s, e, q);
        chk("update event", 16'(m != 2), 16'(e));
        chk("update request", 16'(m == 0 || (m == 1 && s == 0)),
            16'(q));
      end
    end
    done("sources");
    wr(OFS_CTRL_ONE, 16'h0080);
    wr(OFS_RELOAD, 16'h00A5);
    wr(OFS_PRESCALE, 16'h0011);
    wr(OFS_COMPARE, 16'h0022);
    chk("reload", 16'h0000, rld);
    wr(OFS_CTRL_ONE, 16'h0082);
    cause(0, e, q);
    chk("prescale", 16'h0000, prescale_value);
    wr(OFS_CTRL_ONE, 16'h0080);
    cause(1, e, q);
    chk("reload", 16'h00A5, rld);
    chk("prescale", 16'h0011, prescale_value);
    chk("compare", 16'h0022, cmp);
    wr(OFS_CTRL_ONE, 16'h0000);
    wr(OFS_RELOAD, 16'h0033);
    chk("reload", 16'h0033, rld);
    done("buffers");
    wr(OFS_STATUS, 16'h0007);
    cause(0, e, q);
    chk("irq", 16'h0000, 16'(irq));
    wr(OFS_MASK, 16'h0001);
    chk("irq", 16'h0001, 16'(irq));
    rd(OFS_STATUS, v);
    chk("status", 16'h0001, v);
    wr(OFS_STATUS, 16'h0001);
    chk("irq", 16'h0000, 16'(irq));
    done("interrupt");
    wr(OFS_CTRL_ONE, 16'h0009);
    chk("run", 16'h0001, 16'(run));
    cause(1, e, q);
    chk("run", 16'h0000, 16'(run));
    rd(OFS_CTRL_ONE, v);
    chk("control one", 16'h0008, v);
    done("one shot");
    // Sixteen cycles hold whole periods, so the phase does not matter
    for (int c = 0; c < 4; c++) begin
      wr(OFS_CTRL_ONE, 16'(c << 8));
      n = 0;
      repeat (16) begin
        @(posedge clk);
        #1;
        if (tick === 1'b1) begin
          n++;
        end
      end
      chk("ticks", 16'(16 >> (c % 3)), 16'(n));
    end
    done("divider");
    wr(OFS_CTRL_ONE, 16'h0000);
    wr(OFS_CHAN, 16'h0053);
    chk("channel", 16'h0053, chan);
    wr(OFS_CTRL_TWO, 16'h0001);
    wr(OFS_CHAN, 16'h0020);
    chk("channel", 16'h0053, chan);
    wr(OFS_COMMAND, 16'h0002);
    chk("channel", 16'h0020, chan);
    wr(OFS_CHAN, 16'h0041);
    trig();
    chk("channel", 16'h0020, chan);
    wr(OFS_CTRL_TWO, 16'h0005);
    trig();
    chk("channel", 16'h0041, chan);
    rd(OFS_STATUS, v);
    chk("status", 16'h0003, v);
    wr(OFS_MASK, 16'h0002);
    chk("irq", 16'h0001, 16'(irq));
    done("channel");
    summarize();
  end
endmodule
